/* core/sos_pkg.sv */
// ==========================================================
// stream output stage shared definitions
package sos_pkg;

  // ==========================================================
  // register map, byte addresses on the apb bus
  localparam logic [11:0] SOS_OFF_CTRL = 12'h000;
  localparam logic [11:0] SOS_OFF_STATUS = 12'h004;
  localparam logic [11:0] SOS_OFF_STREAM = 12'h010;
  localparam logic [11:0] SOS_OFF_PITCH = 12'h020;
  localparam logic [11:0] SOS_OFF_END = 12'h030;
  localparam logic [11:0] SOS_OFF_WOFF = 12'h040;
  localparam logic [11:0] SOS_OFF_DECL = 12'h080;
  localparam logic [11:0] SOS_OFF_STATS = 12'h100;
  localparam logic [11:0] SOS_SPAN_QUAD = 12'h010;
  localparam logic [11:0] SOS_SPAN_DECL = 12'h040;

  // ==========================================================
  // field positions
  localparam int SOS_CTRL_SO_EN = 0;
  localparam int SOS_CTRL_RND_DIS = 1;
  localparam int SOS_CTRL_RND_TAG = 2;
  localparam int SOS_CTRL_BUF_EN = 4;
  localparam int SOS_STAT_BUSY = 0;
  localparam int SOS_STAT_OVF = 4;
  localparam int SOS_STREAM_CNT = 4;
  localparam int SOS_DECL_DW = 2;

  // ==========================================================
  // reset values and limits
  localparam logic SOS_RST_TOPO_READY = 1'b1;
  localparam logic [2:0] SOS_MAX_ENTRIES = 3'h4;
  localparam logic [23:0] SOS_NO_OBJECT = 24'hFFFFFF;

  // ==========================================================
  // topology and state encodings
  typedef enum logic [3:0] {
    SOS_POINT_LIST = 4'h0,
    SOS_LINE_LIST = 4'h1,
    SOS_LINE_LIST_ADJ = 4'h2,
    SOS_LINE_STRIP = 4'h3,
    SOS_LINE_STRIP_ADJ = 4'h4,
    SOS_TRI_LIST = 4'h5,
    SOS_TRI_LIST_ADJ = 4'h6,
    SOS_TRI_STRIP = 4'h7,
    SOS_REVERSED_TRIANGLE_STRIP = 4'h8,
    SOS_ADJACENCY_TRIANGLE_STRIP = 4'h9,
    SOS_TRIANGLE_FAN = 4'hA,
    SOS_PATCH_LIST_TOPOLOGY = 4'hB,
    SOS_QUAD_LIST_TOPOLOGY = 4'hC
  } sos_topo_e;

  typedef enum logic [1:0] {
    SOS_IDLE = 2'h0,
    SOS_OBJ = 2'h1,
    SOS_VTX = 2'h2
  } sos_fsm_e;

  typedef struct packed {
    sos_fsm_e st;
    logic topo_rdy;
    logic fwd_vld;
    logic [3:0] fwd_typ;
    logic [15:0] fwd_cnt;
    logic [1:0] fwd_tag;
    sos_topo_e typ;
    logic [15:0] n;
    logic [1:0] tag;
    logic trail;
    logic [5:0] psz;
    logic [15:0] k;
    logic [4:0] j;
    logic [1:0] e;
    logic wr_vld;
    logic [1:0] wr_buf;
    logic [15:0] wr_vtx;
    logic [31:0] wr_off;
    logic [3:0] wr_dw;
    logic [1:0] wr_ent;
    logic so_en;
    logic rnd_dis;
    logic [1:0] rnd_tag;
    logic [3:0] buf_en;
    logic [3:0] ovf;
    logic [3:0][3:0] tgt;
    logic [3:0][2:0] ent_cnt;
    logic [3:0][31:0] pitch;
    logic [3:0][31:0] end_addr;
    logic [3:0][31:0] woff;
    logic [15:0][5:0] decl;
    logic [3:0][63:0] prims_written;
    logic [3:0][63:0] storage_needed;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } sos_state_s;

endpackage

/* core/sos_stream_output.sv */
`timescale 1ns/1ps
`default_nettype none

module sos_stream_output (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic topo_valid,
  output logic topo_ready,
  input wire logic [3:0] topo_type,
  input wire logic [15:0] topo_count,
  input wire logic [1:0] topo_stream_tag,
  input wire logic topo_trailing,
  input wire logic [5:0] topo_patch_size,
  output logic fwd_valid,
  output logic [3:0] fwd_type,
  output logic [15:0] fwd_count,
  output logic [1:0] fwd_stream_tag,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [1:0] wr_buffer,
  output logic [15:0] wr_vertex,
  output logic [31:0] wr_offset,
  output logic [3:0] wr_dwords,
  output logic [1:0] wr_entry
);

  // ==========================================================
  // object ordering helpers
  // vertex j of object k; adjacency-only vertices are skipped here
  function automatic logic [15:0] vtx_of(sos_pkg::sos_topo_e t, logic tr, logic [15:0] k,
                                         logic [4:0] j, logic [5:0] p);
    logic [15:0] k2;
    logic [15:0] v0;
    logic [15:0] v1;
    logic [15:0] v2;
    logic [15:0] r;
    k2 = {k[14:0], 1'b0};
    v0 = k;
    v1 = 16'(k + 16'h1);
    v2 = 16'(k + 16'h2);
    r = 16'h0;
    case (t)
      sos_pkg::SOS_LINE_LIST: begin
        v0 = k2;
        v1 = 16'(k2 + 16'h1);
      end
      sos_pkg::SOS_LINE_LIST_ADJ: begin
        v0 = 16'({k2[14:0], 1'b0} + 16'h1);
        v1 = 16'({k2[14:0], 1'b0} + 16'h2);
      end
      sos_pkg::SOS_LINE_STRIP_ADJ: begin
        v0 = 16'(k + 16'h1);
        v1 = 16'(k + 16'h2);
      end
      sos_pkg::SOS_TRI_LIST: begin
        v0 = 16'(k2 + k);
        v1 = 16'(k2 + k + 16'h1);
        v2 = 16'(k2 + k + 16'h2);
      end
      sos_pkg::SOS_TRI_LIST_ADJ: begin
        v0 = 16'({k2[14:0], 1'b0} + k2);
        v1 = 16'(v0 + 16'h2);
        v2 = 16'(v0 + 16'h4);
      end
      sos_pkg::SOS_TRI_STRIP: begin
        if (k[0] && tr) begin
          v0 = 16'(k + 16'h1);
          v1 = k;
        end else if (k[0]) begin
          v1 = 16'(k + 16'h2);
          v2 = 16'(k + 16'h1);
        end
      end
      sos_pkg::SOS_REVERSED_TRIANGLE_STRIP: begin
        if (!k[0] && tr) begin
          v0 = 16'(k + 16'h1);
          v1 = k;
        end else if (!k[0]) begin
          v1 = 16'(k + 16'h2);
          v2 = 16'(k + 16'h1);
        end
      end
      sos_pkg::SOS_ADJACENCY_TRIANGLE_STRIP: begin
        v0 = k2;
        v1 = 16'(k2 + 16'h2);
        v2 = 16'(k2 + 16'h4);
        if (k[0] && tr) begin
          v0 = 16'(k2 + 16'h2);
          v1 = k2;
        end else if (k[0]) begin
          v1 = 16'(k2 + 16'h4);
          v2 = 16'(k2 + 16'h2);
        end
      end
      sos_pkg::SOS_TRIANGLE_FAN: begin
        v0 = 16'h0;
      end
      default: begin
      end
    endcase
    if (t == sos_pkg::SOS_PATCH_LIST_TOPOLOGY) begin
      r = 16'(k * p + 22'(j));
    end else if (j == 5'h0) begin
      r = v0;
    end else if (j == 5'h1) begin
      r = v1;
    end else begin
      r = v2;
    end
    return r;
  endfunction

  // highest input vertex that object k covers; objects past the count do not exist
  function automatic logic [23:0] ext_of(sos_pkg::sos_topo_e t, logic [15:0] k, logic [5:0] p);
    logic [23:0] kk;
    kk = 24'(k);
    case (t)
      sos_pkg::SOS_POINT_LIST: ext_of = kk;
      sos_pkg::SOS_LINE_LIST: ext_of = 24'(2 * kk + 1);
      sos_pkg::SOS_LINE_LIST_ADJ: ext_of = 24'(4 * kk + 3);
      sos_pkg::SOS_LINE_STRIP: ext_of = 24'(kk + 1);
      sos_pkg::SOS_LINE_STRIP_ADJ: ext_of = 24'(kk + 3);
      sos_pkg::SOS_TRI_LIST: ext_of = 24'(3 * kk + 2);
      sos_pkg::SOS_TRI_LIST_ADJ: ext_of = 24'(6 * kk + 5);
      sos_pkg::SOS_ADJACENCY_TRIANGLE_STRIP: ext_of = 24'(2 * kk + 5);
      sos_pkg::SOS_TRI_STRIP, sos_pkg::SOS_REVERSED_TRIANGLE_STRIP,
      sos_pkg::SOS_TRIANGLE_FAN: ext_of = 24'(kk + 2);
      sos_pkg::SOS_PATCH_LIST_TOPOLOGY: ext_of = 24'(kk * 24'(p) + 24'(p) - 24'h1);
      default: ext_of = sos_pkg::SOS_NO_OBJECT;
    endcase
  endfunction

  // vertices per output object
  function automatic logic [5:0] nv_of(sos_pkg::sos_topo_e t, logic [5:0] p);
    case (t)
      sos_pkg::SOS_POINT_LIST: nv_of = 6'h01;
      sos_pkg::SOS_LINE_LIST, sos_pkg::SOS_LINE_LIST_ADJ, sos_pkg::SOS_LINE_STRIP,
      sos_pkg::SOS_LINE_STRIP_ADJ: nv_of = 6'h02;
      sos_pkg::SOS_PATCH_LIST_TOPOLOGY: nv_of = p;
      default: nv_of = 6'h03;
    endcase
  endfunction

  // address window test, shared by read and write decode
  function automatic logic in_win(logic [11:0] a, logic [11:0] base, logic [11:0] span);
    return (a >= base) && (a < 12'(base + span));
  endfunction

  sos_pkg::sos_state_s s_q;
  sos_pkg::sos_state_s s_d;

  // ==========================================================
  // next-state logic
  always_comb begin
    logic [3:0] ovf_set;
    logic [3:0] ovf_vec;
    logic [3:0] clr;
    logic [39:0] need;
    logic [5:0] nv;
    logic [4:0] jn;
    logic [1:0] en;
    logic issue;
    logic [5:0] ent;
    logic [3:0] di;
    logic [11:0] a;
    logic xfer;
    logic hit;
    logic [31:0] rd;
    ovf_set = 4'h0;
    ovf_vec = 4'h0;
    clr = 4'h0;
    need = 40'h0;
    nv = nv_of(s_q.typ, s_q.psz);
    jn = 5'h0;
    en = 2'h0;
    issue = 1'b0;
    ent = 6'h0;
    di = 4'h0;
    a = paddr;
    xfer = psel && penable && s_q.pready;
    hit = 1'b1;
    rd = 32'h0;
    s_d = s_q;
    s_d.fwd_vld = 1'b0;

    case (s_q.st)
      sos_pkg::SOS_IDLE: begin
        if (topo_valid && s_q.topo_rdy) begin
          s_d.typ = sos_pkg::sos_topo_e'(topo_type);
          s_d.n = topo_count;
          s_d.tag = topo_stream_tag;
          s_d.trail = topo_trailing;
          s_d.psz = topo_patch_size;
          s_d.k = 16'h0;
          // forwarded unmodified, only for the selected stream, never patches
          s_d.fwd_vld = !s_q.rnd_dis && (topo_stream_tag == s_q.rnd_tag) &&
                        (topo_type != sos_pkg::SOS_PATCH_LIST_TOPOLOGY);
          s_d.fwd_typ = topo_type;
          s_d.fwd_cnt = topo_count;
          s_d.fwd_tag = topo_stream_tag;
          // an empty list means no stream output at all
          if (s_q.so_en && s_q.ent_cnt[topo_stream_tag] != 3'h0) begin
            s_d.st = sos_pkg::SOS_OBJ;
            s_d.topo_rdy = 1'b0;
          end
        end
      end
      sos_pkg::SOS_OBJ: begin
        if (ext_of(s_q.typ, s_q.k, s_q.psz) >= 24'(s_q.n)) begin
          s_d.st = sos_pkg::SOS_IDLE;
          s_d.topo_rdy = 1'b1;
        end else begin
          for (int b = 0; b < 4; b++) begin
            need = 40'(s_q.woff[b]) + 40'(nv) * 40'(s_q.pitch[b]);
            ovf_vec[b] = s_q.tgt[s_q.tag][b] &&
                         (!s_q.buf_en[b] || need > 40'(s_q.end_addr[b]));
            if (s_q.tgt[s_q.tag][b]) begin
              s_d.storage_needed[b] = 64'(s_q.storage_needed[b] + 64'h1);
            end
          end
          if (ovf_vec != 4'h0) begin
            ovf_set = ovf_vec;
            s_d.k = 16'(s_q.k + 16'h1);
          end else begin
            for (int b = 0; b < 4; b++) begin
              if (s_q.tgt[s_q.tag][b]) begin
                s_d.prims_written[b] = 64'(s_q.prims_written[b] + 64'h1);
              end
            end
            s_d.st = sos_pkg::SOS_VTX;
            issue = 1'b1;
          end
        end
      end
      sos_pkg::SOS_VTX: begin
        // one declaration entry per write, held until the sink takes it
        if (wr_ready) begin
          s_d.woff[s_q.wr_buf] = 32'(s_q.woff[s_q.wr_buf] + {26'h0, s_q.wr_dw, 2'h0});
          s_d.wr_vld = 1'b0;
          if (3'(s_q.e) + 3'h1 < s_q.ent_cnt[s_q.tag]) begin
            en = 2'(s_q.e + 2'h1);
            jn = s_q.j;
            issue = 1'b1;
          end else if (6'(s_q.j) + 6'h1 < nv) begin
            jn = 5'(s_q.j + 5'h1);
            issue = 1'b1;
          end else begin
            s_d.k = 16'(s_q.k + 16'h1);
            s_d.st = sos_pkg::SOS_OBJ;
          end
        end
      end
      default: begin
        s_d.st = sos_pkg::SOS_IDLE;
        s_d.topo_rdy = 1'b1;
      end
    endcase

    // launch the write for vertex jn, entry en of the current object
    if (issue) begin
      di = {s_q.tag, en};
      ent = s_q.decl[di];
      s_d.j = jn;
      s_d.e = en;
      s_d.wr_vld = 1'b1;
      s_d.wr_buf = ent[1:0];
      s_d.wr_dw = ent[5:2];
      s_d.wr_ent = en;
      s_d.wr_vtx = vtx_of(s_q.typ, s_q.trail, s_q.k, jn, s_q.psz);
      s_d.wr_off = s_d.woff[ent[1:0]];
    end

    // ==========================================================
    // apb slave: one wait state, read data registered with pready one edge early, write at the completing edge
    s_d.pready = psel && penable && !s_q.pready;
    if (a == sos_pkg::SOS_OFF_CTRL) begin
      rd = {24'h0, s_q.buf_en, s_q.rnd_tag, s_q.rnd_dis, s_q.so_en};
      if (xfer && pwrite) begin
        s_d.so_en = pwdata[sos_pkg::SOS_CTRL_SO_EN];
        s_d.rnd_dis = pwdata[sos_pkg::SOS_CTRL_RND_DIS];
        s_d.rnd_tag = pwdata[sos_pkg::SOS_CTRL_RND_TAG +: 2];
        s_d.buf_en = pwdata[sos_pkg::SOS_CTRL_BUF_EN +: 4];
      end
    end else if (a == sos_pkg::SOS_OFF_STATUS) begin
      rd = {24'h0, s_q.ovf, 3'h0, s_q.st != sos_pkg::SOS_IDLE};
      if (xfer && pwrite) begin
        clr = pwdata[sos_pkg::SOS_STAT_OVF +: 4];
      end
    end else if (in_win(a, sos_pkg::SOS_OFF_STREAM, sos_pkg::SOS_SPAN_QUAD)) begin
      rd = {25'h0, s_q.ent_cnt[a[3:2]], s_q.tgt[a[3:2]]};
      if (xfer && pwrite) begin
        s_d.tgt[a[3:2]] = pwdata[3:0];
        s_d.ent_cnt[a[3:2]] = (pwdata[6:4] > sos_pkg::SOS_MAX_ENTRIES) ?
                              sos_pkg::SOS_MAX_ENTRIES : pwdata[6:4];
      end
    end else if (in_win(a, sos_pkg::SOS_OFF_PITCH, sos_pkg::SOS_SPAN_QUAD)) begin
      rd = s_q.pitch[a[3:2]];
      if (xfer && pwrite) begin
        s_d.pitch[a[3:2]] = pwdata;
      end
    end else if (in_win(a, sos_pkg::SOS_OFF_END, sos_pkg::SOS_SPAN_QUAD)) begin
      rd = s_q.end_addr[a[3:2]];
      if (xfer && pwrite) begin
        s_d.end_addr[a[3:2]] = pwdata;
      end
    end else if (in_win(a, sos_pkg::SOS_OFF_WOFF, sos_pkg::SOS_SPAN_QUAD)) begin
      // a software load lands after any output increment in the same cycle
      rd = s_q.woff[a[3:2]];
      if (xfer && pwrite) begin
        s_d.woff[a[3:2]] = pwdata;
      end
    end else if (in_win(a, sos_pkg::SOS_OFF_DECL, sos_pkg::SOS_SPAN_DECL)) begin
      rd = {26'h0, s_q.decl[a[5:2]]};
      if (xfer && pwrite) begin
        s_d.decl[a[5:2]] = pwdata[5:0];
      end
    end else if (in_win(a, sos_pkg::SOS_OFF_STATS, sos_pkg::SOS_SPAN_DECL)) begin
      // counters read only; low word at +0, high at +4, needed at +8/+C
      case (a[3:2])
        2'h0: rd = s_q.prims_written[a[5:4]][31:0];
        2'h1: rd = s_q.prims_written[a[5:4]][63:32];
        2'h2: rd = s_q.storage_needed[a[5:4]][31:0];
        default: rd = s_q.storage_needed[a[5:4]][63:32];
      endcase
    end else begin
      hit = 1'b0;
    end
    if (s_d.pready) begin
      s_d.prdata = rd;
      s_d.pslverr = !hit;
    end else begin
      s_d.prdata = 32'h0;
      s_d.pslverr = 1'b0;
    end

    // sticky overflow: a new overflow wins over a clear in the same cycle
    s_d.ovf = (s_q.ovf & ~clr) | ovf_set;
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.topo_rdy <= sos_pkg::SOS_RST_TOPO_READY;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs straight from the state flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign topo_ready = s_q.topo_rdy;
  assign fwd_valid = s_q.fwd_vld;
  assign fwd_type = s_q.fwd_typ;
  assign fwd_count = s_q.fwd_cnt;
  assign fwd_stream_tag = s_q.fwd_tag;
  assign wr_valid = s_q.wr_vld;
  assign wr_buffer = s_q.wr_buf;
  assign wr_vertex = s_q.wr_vtx;
  assign wr_offset = s_q.wr_off;
  assign wr_dwords = s_q.wr_dw;
  assign wr_entry = s_q.wr_ent;

endmodule // sos_stream_output

`default_nettype wire

/* testbench/sos_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker bound onto the stream output stage
module sos_port_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic topo_valid,
  input wire logic topo_ready,
  input wire logic [3:0] topo_type,
  input wire logic [15:0] topo_count,
  input wire logic [1:0] topo_stream_tag,
  input wire logic fwd_valid,
  input wire logic [3:0] fwd_type,
  input wire logic [15:0] fwd_count,
  input wire logic [1:0] fwd_stream_tag,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [1:0] wr_buffer,
  input wire logic [15:0] wr_vertex,
  input wire logic [31:0] wr_offset,
  input wire logic [3:0] wr_dwords
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // register bus timing, one wait state by design
  chk_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  // ==========================================================
  // forwarding is an exact copy of the taken header
  chk_fwd_copy: assert property (fwd_valid |-> $past(topo_valid && topo_ready)
    && fwd_type == $past(topo_type) && fwd_count == $past(topo_count) && fwd_stream_tag == $past(topo_stream_tag))
    else $error("forwarded header differs from taken one");
  chk_no_patch: assert property (fwd_valid |-> fwd_type != 4'hB)
    else $error("patch list forwarded");
  // stalled writes must keep offset, vertex, buffer and dwords still
  chk_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_offset) && $stable(wr_vertex)
    && $stable(wr_buffer) && $stable(wr_dwords))
    else $error("write fields moved while stalled");
  chk_wr_step: assert property ((wr_valid && wr_ready ##1 wr_valid && wr_buffer == $past(wr_buffer))
    |-> wr_offset == $past(wr_offset) + {$past(wr_dwords), 2'h0})
    else $error("write offset step wrong");
  cover property (fwd_valid);
  cover property (wr_valid && !wr_ready ##1 wr_valid && wr_ready);
  cover property (pslverr);
endmodule // sos_port_chk
`default_nettype wire

/* testbench/sos_wr_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// buffer memory side, answers promptly or every other cycle
module sos_wr_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic wr_valid,
  output logic wr_ready
);
  // slow mode stalls pending writes to exercise the hold path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ready <= 1'h0;
    end else begin
      wr_ready <= slow ? (wr_valid & ~wr_ready) : 1'h1;
    end
  end
endmodule // sos_wr_sink
`default_nettype wire

/* testbench/sos_stream_output_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define sos_chk(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
// ==========================================================
// bench top: apb setup, topology feed, write capture
module sos_stream_output_tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, wr_offset;
  logic pready, pslverr, er, topo_ready, fwd_valid, wr_valid, wr_ready;
  logic topo_valid = 1'h0, topo_trailing = 1'h0, slow = 1'h0, rdis = 1'h0;
  logic [3:0] topo_type = 4'h0, fwd_type, wr_dwords;
  logic [15:0] topo_count = 16'h0, fwd_count, wr_vertex;
  logic [1:0] topo_stream_tag = 2'h0, fwd_stream_tag, wr_buffer, wr_entry;
  logic [5:0] topo_patch_size = 6'h01;
  int err_count = 0, samples_checked = 0, cyc = 0, n_fwd = 0, wr_tot = 0, pw0 = 0, st0 = 0;
  logic [15:0] got[$], exq[$];
  logic [39:0] gof[$];

  sos_stream_output dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .topo_valid(topo_valid),
    .topo_ready(topo_ready), .topo_type(topo_type), .topo_count(topo_count),
    .topo_stream_tag(topo_stream_tag), .topo_trailing(topo_trailing), .topo_patch_size(topo_patch_size),
    .fwd_valid(fwd_valid), .fwd_type(fwd_type), .fwd_count(fwd_count), .fwd_stream_tag(fwd_stream_tag),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_buffer(wr_buffer), .wr_vertex(wr_vertex),
    .wr_offset(wr_offset), .wr_dwords(wr_dwords), .wr_entry(wr_entry)
  );
  sos_wr_sink sink (.pclk(pclk), .presetn(presetn), .slow(slow), .wr_valid(wr_valid), .wr_ready(wr_ready));

  // 40 MHz
  always #12.5 pclk = ~pclk;

  // capture accepted writes and forwards; a hang ends the run here
  always @(posedge pclk) begin
    cyc++;
    if (wr_valid === 1'h1 && wr_ready === 1'h1) begin
      got.push_back(wr_vertex);
      gof.push_back({wr_buffer, wr_dwords, wr_entry, wr_offset});
    end
    if (fwd_valid === 1'h1) begin
      n_fwd++;
    end
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    // a slave that never answers is a failure, not a silent skip
    if (pready !== 1'h1) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `sos_chk(rd, e)
  endtask

  // vertex i of object k, worked out from the ordering tables
  function automatic int vtx(input logic [3:0] t, input logic tr, input int k, input int i, input int p);
    int a[3];
    a = '{3 * k, 3 * k + 1, 3 * k + 2};
    if (t == 4'h8 && k % 2 == 0) a = '{k + 1, k, k + 2};
    if (t == 4'h8 && k % 2 == 1) a = '{k, k + 1, k + 2};
    if (t == 4'h9) a = '{2 * k, 2 * k + 2, 2 * k + 4};
    if (t == 4'h9 && k % 2 == 1 && tr) a = '{2 * k + 2, 2 * k, 2 * k + 4};
    if (t == 4'h9 && k % 2 == 1 && !tr) a = '{2 * k, 2 * k + 4, 2 * k + 2};
    if (t == 4'hA) a = '{0, k + 1, k + 2};
    if (t == 4'h6) a = '{6 * k, 6 * k + 2, 6 * k + 4};
    if (t == 4'h4) a = '{k + 1, k + 2, 0};
    if (t == 4'hB) return k * p + i;
    return a[i];
  endfunction

  // feed one topology, wait for its objects, compare writes and forwards
  task automatic run(input logic [3:0] t, input int n, input logic [1:0] s, input logic tr, input int p,
                     input logic ov);
    int no, nv, f0, c;
    no = (t == 4'hB) ? n / p : (t == 4'h9) ? n / 2 - 2 : (t == 4'h5) ? n / 3 :
         (t == 4'h6) ? n / 6 : (t == 4'h4) ? n - 3 : n - 2;
    nv = (t == 4'hB) ? p : (t == 4'h4) ? 2 : 3;
    got.delete();
    gof.delete();
    exq.delete();
    f0 = n_fwd;
    c = 0;
    if (s == 2'h1) st0 += no;
    if (s == 2'h1 && !ov) begin
      pw0 += no;
      wr_tot += no * nv;
      for (int k = 0; k < no; k++) for (int i = 0; i < nv; i++) exq.push_back(16'(vtx(t, tr, k, i, p)));
    end
    @(posedge pclk);
    topo_valid <= 1'h1;
    topo_type <= t;
    topo_count <= 16'(n);
    topo_stream_tag <= s;
    topo_trailing <= tr;
    topo_patch_size <= 6'(p);
    do begin
      @(posedge pclk);
      c++;
    end while (topo_ready !== 1'h1 && c < 100);
    topo_valid <= 1'h0;
    @(posedge pclk);
    while (topo_ready !== 1'h1 && c < 3000) begin
      @(posedge pclk);
      c++;
    end
    if (topo_ready !== 1'h1) err_count++;
    repeat (2) @(posedge pclk);
    `sos_chk(got.size(), exq.size())
    // buffer 0, two dwords, entry 0; offsets run on from the last write
    foreach (exq[x]) begin
      `sos_chk(got[x], exq[x])
      `sos_chk(gof[x], {8'h08, 32'((wr_tot - no * nv + x) * 8)})
    end
    `sos_chk(n_fwd - f0, (t != 4'hB && s == 2'h1 && !rdis) ? 1 : 0)
  endtask

  // ==========================================================
  // main sequence; upstream never feeds quad topologies
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    // stream 1 to buffer 0 at two dwords a vertex, stream 3 aims at disabled buffer 1
    apb(1'h1, 12'h000, 32'h00000015);
    apb(1'h1, 12'h014, 32'h00000011);
    apb(1'h1, 12'h01C, 32'h00000012);
    apb(1'h1, 12'h090, 32'h00000008);
    apb(1'h1, 12'h0B0, 32'h00000005);
    apb(1'h1, 12'h020, 32'h00000008);
    apb(1'h1, 12'h030, 32'h00001000);
    run(4'h8, 5, 2'h1, 1'h1, 1, 1'h0);
    slow <= 1'h1;
    run(4'h9, 10, 2'h1, 1'h0, 1, 1'h0);
    run(4'h9, 10, 2'h1, 1'h1, 1, 1'h0);
    slow <= 1'h0;
    run(4'hA, 5, 2'h1, 1'h0, 1, 1'h0);
    run(4'hB, 6, 2'h1, 1'h0, 3, 1'h0);
    run(4'h6, 12, 2'h1, 1'h0, 1, 1'h0);
    run(4'h4, 5, 2'h1, 1'h0, 1, 1'h0);
    rdc(12'h040, 32'(wr_tot * 8));
    rdc(12'h100, 32'(pw0));
    rdc(12'h104, 32'h0);
    rdc(12'h108, 32'(st0));
    run(4'h5, 3, 2'h2, 1'h0, 1, 1'h0);
    rdc(12'h004, 32'h0);
    run(4'h5, 3, 2'h3, 1'h0, 1, 1'h1);
    rdc(12'h004, 32'h00000020);
    rdc(12'h110, 32'h0);
    rdc(12'h118, 32'h1);
    apb(1'h1, 12'h004, 32'h000000F0);
    rdc(12'h004, 32'h0);
    // end address one short of three vertices, then exactly enough
    apb(1'h1, 12'h040, 32'h0);
    wr_tot = 0;
    apb(1'h1, 12'h030, 32'h00000017);
    run(4'h5, 3, 2'h1, 1'h0, 1, 1'h1);
    rdc(12'h004, 32'h00000010);
    apb(1'h1, 12'h030, 32'h00000018);
    run(4'h5, 3, 2'h1, 1'h0, 1, 1'h0);
    rdc(12'h040, 32'h00000018);
    // room again, so the unrendered fan is still written out
    apb(1'h1, 12'h030, 32'h00001000);
    apb(1'h1, 12'h000, 32'h00000017);
    rdis <= 1'h1;
    run(4'hA, 3, 2'h1, 1'h0, 1, 1'h0);
    apb(1'h1, 12'h100, 32'h0000FFFF);
    rdc(12'h100, 32'(pw0));
    rdc(12'h108, 32'(st0));
    rdc(12'h0FC, 32'h0);
    `sos_chk(er, 1'h1)
    stop_test();
  end
endmodule // sos_stream_output_tb

bind sos_stream_output sos_port_chk chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .topo_valid(topo_valid), .topo_ready(topo_ready), .topo_type(topo_type),
  .topo_count(topo_count), .topo_stream_tag(topo_stream_tag), .fwd_valid(fwd_valid), .fwd_type(fwd_type),
  .fwd_count(fwd_count), .fwd_stream_tag(fwd_stream_tag), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_buffer(wr_buffer), .wr_vertex(wr_vertex), .wr_offset(wr_offset), .wr_dwords(wr_dwords)
);
`default_nettype wire
